// file: inc/mct_pkg.sv
// Purpose: shared constants of the match/capture counter-timer
// Assumes: 32-bit register port, byte offsets on word boundaries
// Notes:   all offsets, field positions and reset values live here
package mct_pkg;
   localparam int          CNT_W       = 32;
   localparam int          HALF_W      = 16;
   localparam int          ADDR_W      = 8;
   localparam int          N_MATCH     = 4;
   localparam int          N_CAP       = 2;
   localparam logic [31:0] RST_WORD    = 32'h0;
   ////////////////////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0]  OFF_STAT    = 8'h00;
   localparam logic [7:0]  OFF_MASK    = 8'h04;
   localparam logic [7:0]  OFF_CTRL    = 8'h08;
   localparam logic [7:0]  OFF_COUNT   = 8'h0c;
   localparam logic [7:0]  OFF_PRESC   = 8'h10;
   localparam logic [7:0]  OFF_PCOUNT  = 8'h14;
   localparam logic [7:0]  OFF_MCTL    = 8'h18;
   localparam logic [7:0]  OFF_CCTL    = 8'h1c;
   localparam logic [7:0]  OFF_EXT     = 8'h20;
   localparam logic [7:0]  OFF_MATCH0  = 8'h30;
   localparam logic [7:0]  OFF_CAPT0   = 8'h40;
   localparam logic [7:0]  OFF_STRIDE  = 8'h04;
   ////////////////////////////////////////////////////////////////////////////////////////////////
   localparam int          CTRL_EN     = 0;
   localparam int          CTRL_RST    = 1;
   localparam int          CTRL_MODE   = 2;
   localparam int          CTRL_CSEL   = 4;
   localparam int          MCTL_INT    = 0;
   localparam int          MCTL_RST    = 1;
   localparam int          MCTL_STOP   = 2;
   localparam int          MCTL_W      = 3;
   localparam int          CCTL_RISE   = 0;
   localparam int          CCTL_FALL   = 1;
   localparam int          CCTL_INT    = 2;
   localparam int          CCTL_W      = 3;
   localparam int          CCLR_EN     = 6;
   localparam int          CCLR_SEL    = 7;
   localparam int          CCLR_FALL   = 8;
   localparam int          EXT_ACT     = 4;
   localparam int          STAT_CAP    = 4;
   ////////////////////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {MODE_TIMER = 2'h0, MODE_RISE = 2'h1, MODE_FALL = 2'h2, MODE_BOTH = 2'h3}
      mct_mode_type;
   typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_LOW = 2'h1, ACT_HIGH = 2'h2, ACT_TOGGLE = 2'h3}
      mct_act_type;
endpackage

// file: inc/mct_cap_if.sv
// Purpose: link between the core and one capture channel
// Assumes: pin already synchronous to the clock
// Notes:   event outputs are one-cycle pulses
`timescale 1ns/1ps
interface mct_cap_if;
   logic                      pin;
   logic [mct_pkg::CNT_W-1:0] count;
   logic                      rise_en;
   logic                      fall_en;
   logic                      rise_ev;
   logic                      fall_ev;
   logic                      cap_ev;
   logic [mct_pkg::CNT_W-1:0] value;
   modport unit (input pin, input count, input rise_en, input fall_en,
                 output rise_ev, output fall_ev, output cap_ev, output value);
   modport core (output pin, output count, output rise_en, output fall_en,
                 input rise_ev, input fall_ev, input cap_ev, input value);
endinterface

// file: src/mct_capture.sv
// Purpose: edge detection and count snapshot for one capture input
// Assumes: pin synchronous to clk
// Notes:   snapshot is the count seen in the edge cycle
`timescale 1ns/1ps
module mct_capture (
   input wire logic clk,
   input wire logic arst_n,
   mct_cap_if.unit  cif
);
   logic prev_ff;
   logic rise;
   logic fall;

   assign rise = cif.pin & ~prev_ff;
   assign fall = ~cif.pin & prev_ff;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_ff     <= 1'b0;
         cif.rise_ev <= 1'b0;
         cif.fall_ev <= 1'b0;
         cif.cap_ev  <= 1'b0;
      end else begin
         prev_ff     <= cif.pin;
         cif.rise_ev <= rise;
         cif.fall_ev <= fall;
         cif.cap_ev  <= (rise & cif.rise_en) | (fall & cif.fall_en);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cif.value <= mct_pkg::RST_WORD;
      end else if ((rise & cif.rise_en) | (fall & cif.fall_en)) begin
         cif.value <= cif.count;
      end
   end

   a_capture_latch : assert property (@(posedge clk) disable iff (!arst_n)
      (rise & cif.rise_en) |=> (cif.value == $past(cif.count)) && cif.cap_ev)
      else $error("capture did not latch the count");
   a_capture_quiet : assert property (@(posedge clk) disable iff (!arst_n)
      !(rise | fall) |=> $stable(cif.value) && !cif.cap_ev)
      else $error("capture changed without an edge");
endmodule

// file: src/mct_prescale.sv
// Purpose: prescaler that divides the clock into counter ticks
// Assumes: limit already trimmed to the counter width
// Notes:   a limit lowered below the count wraps at once
`timescale 1ns/1ps
module mct_prescale (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      run,
   input  wire logic                      clr,
   input  wire logic [mct_pkg::CNT_W-1:0] limit,
   output logic      [mct_pkg::CNT_W-1:0] pc,
   output logic                           tick
);
   logic [mct_pkg::CNT_W-1:0] pc_ff;

   assign pc   = pc_ff;
   assign tick = run & ~clr & (pc_ff >= limit);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_ff <= mct_pkg::RST_WORD;
      end else if (clr | tick) begin
         pc_ff <= mct_pkg::RST_WORD;
      end else if (run) begin
         pc_ff <= mct_pkg::CNT_W'(pc_ff + 32'h1);
      end
   end

   a_prescale_wrap : assert property (@(posedge clk) disable iff (!arst_n)
      tick |=> (pc_ff == 32'h0))
      else $error("prescaler did not restart after tick");
   a_prescale_step : assert property (@(posedge clk) disable iff (!arst_n)
      (run & ~clr & ~tick) |=> (pc_ff == $past(pc_ff) + 32'h1))
      else $error("prescaler did not count a cycle");
endmodule

// file: src/mct_timer.sv
// Purpose: counter-timer with four match units and two capture channels
// Assumes: CAP pins synchronous to CLK; register port strobes one cycle long
// Notes:   WIDE32 low gives the 16-bit variant; upper bits then read zero
`timescale 1ns/1ps
// Behaviour
// - counter and prescaler are 32 or 16 bits wide, chosen by WIDE32.
// - in timer mode the counter advances on prescaled system clock cycles.
// - mode field selects timer counting or counting edges on a capture pin.
// - four match registers, each triggering its own actions and optional interrupt.
// - a match may leave the counter running and optionally raise an interrupt.
// - a match may halt the counter, optionally raising an interrupt.
// - a match may return the counter to zero, optionally raising an interrupt.
// - four match outputs each go low, high, toggle or hold on match.
// - two capture channels latch the count on their enabled rising or falling input edges.
// - a capture event can optionally raise an interrupt.
// - a chosen capture edge clears both counter and prescaler.
module mct_timer #(
   parameter bit WIDE32 = 1'b1
) (
   input  wire logic                       CLK,
   input  wire logic                       ARST_N,
   input  wire logic [mct_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [31:0]                WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic      [31:0]                RDATA,
   input  wire logic [mct_pkg::N_CAP-1:0]  CAP,
   output logic      [mct_pkg::N_MATCH-1:0] MAT,
   output logic                            IRQ
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [mct_pkg::CNT_W-1:0] fit(input logic [mct_pkg::CNT_W-1:0] v);
      fit = WIDE32 ? v : {{(mct_pkg::CNT_W-mct_pkg::HALF_W){1'b0}}, v[mct_pkg::HALF_W-1:0]};
   endfunction

   function automatic logic at(input logic [7:0] a, input logic [7:0] base, input int idx);
      at = (a == 8'(base + idx * mct_pkg::OFF_STRIDE));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [31:0]                       stat_ff;
   logic [31:0]                       mask_ff;
   logic                              en_ff;
   logic                              rst_ff;
   mct_pkg::mct_mode_type             mode_ff;
   logic                              csel_ff;
   logic [mct_pkg::CNT_W-1:0]         cnt_ff;
   logic [mct_pkg::CNT_W-1:0]         nxt_cnt;
   logic [mct_pkg::CNT_W-1:0]         presc_ff;
   logic [11:0]                       mctl_ff;
   logic [8:0]                        cctl_ff;
   logic [7:0]                        act_ff;
   logic [mct_pkg::CNT_W-1:0]         match_ff [mct_pkg::N_MATCH];
   logic [mct_pkg::N_MATCH-1:0]       mat_ff;
   logic [mct_pkg::N_MATCH-1:0]       nxt_mat;
   logic [31:0]                       rdata_ff;
   logic [31:0]                       rd_word;
   logic                              irq_ff;
   logic [31:0]                       nxt_stat;
   logic [mct_pkg::CNT_W-1:0]         pc;
   logic                              tick;
   logic                              run;
   logic                              count_edge;
   logic                              advance;
   logic                              cap_clear;
   logic [mct_pkg::N_MATCH-1:0]       hit;
   logic [mct_pkg::N_MATCH-1:0]       hit_rst;
   logic [mct_pkg::N_MATCH-1:0]       hit_stop;
   logic [mct_pkg::N_MATCH-1:0]       hit_int;
   logic [mct_pkg::N_CAP-1:0]         cap_ev;
   logic [mct_pkg::N_CAP-1:0]         rise_ev;
   logic [mct_pkg::N_CAP-1:0]         fall_ev;
   logic [mct_pkg::CNT_W-1:0]         cap_val [mct_pkg::N_CAP];
   logic                              wr_count;

   assign RDATA    = rdata_ff;
   assign MAT      = mat_ff;
   assign IRQ      = irq_ff;
   assign wr_count = WR & (ADDR == mct_pkg::OFF_COUNT);
   assign run      = en_ff & ~rst_ff;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // capture channels
   genvar gc;
   generate
      for (gc = 0; gc < mct_pkg::N_CAP; gc++) begin : g_cap
         mct_cap_if cif ();
         assign cif.pin     = CAP[gc];
         assign cif.count   = cnt_ff;
         assign cif.rise_en = cctl_ff[gc*mct_pkg::CCTL_W + mct_pkg::CCTL_RISE];
         assign cif.fall_en = cctl_ff[gc*mct_pkg::CCTL_W + mct_pkg::CCTL_FALL];
         assign cap_ev[gc]  = cif.cap_ev;
         assign rise_ev[gc] = cif.rise_ev;
         assign fall_ev[gc] = cif.fall_ev;
         assign cap_val[gc] = cif.value;
         mct_capture u_cap (
            .clk    (CLK),
            .arst_n (ARST_N),
            .cif    (cif.unit)
         );
      end
   endgenerate

   // chosen edge of chosen channel clears counter and prescaler
   assign cap_clear = cctl_ff[mct_pkg::CCLR_EN] &
                      (cctl_ff[mct_pkg::CCLR_FALL] ? fall_ev[cctl_ff[mct_pkg::CCLR_SEL]]
                                                   : rise_ev[cctl_ff[mct_pkg::CCLR_SEL]]);

   // counter mode edge source
   always_comb begin
      unique case (mode_ff)
         mct_pkg::MODE_TIMER : count_edge = 1'b0;
         mct_pkg::MODE_RISE  : count_edge = rise_ev[csel_ff];
         mct_pkg::MODE_FALL  : count_edge = fall_ev[csel_ff];
         mct_pkg::MODE_BOTH  : count_edge = rise_ev[csel_ff] | fall_ev[csel_ff];
      endcase
   end

   mct_prescale u_presc (
      .clk    (CLK),
      .arst_n (ARST_N),
      .run    (run & (mode_ff == mct_pkg::MODE_TIMER)),
      .clr    (rst_ff | cap_clear),
      .limit  (presc_ff),
      .pc     (pc),
      .tick   (tick)
   );

   assign advance = run & ~cap_clear & ((mode_ff == mct_pkg::MODE_TIMER) ? tick : count_edge);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // match detection
   genvar gm;
   generate
      for (gm = 0; gm < mct_pkg::N_MATCH; gm++) begin : g_match
         assign hit[gm]      = advance & (cnt_ff == match_ff[gm]);
         assign hit_int[gm]  = hit[gm] & mctl_ff[gm*mct_pkg::MCTL_W + mct_pkg::MCTL_INT];
         assign hit_rst[gm]  = hit[gm] & mctl_ff[gm*mct_pkg::MCTL_W + mct_pkg::MCTL_RST];
         assign hit_stop[gm] = hit[gm] & mctl_ff[gm*mct_pkg::MCTL_W + mct_pkg::MCTL_STOP];
      end
   endgenerate

   always_comb begin
      nxt_cnt = cnt_ff;
      if (wr_count) begin
         nxt_cnt = fit(WDATA);
      end else if (rst_ff | cap_clear) begin
         nxt_cnt = mct_pkg::RST_WORD;
      end else if (|hit_rst) begin
         nxt_cnt = mct_pkg::RST_WORD;
      end else if (advance) begin
         nxt_cnt = fit(mct_pkg::CNT_W'(cnt_ff + 32'h1));
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_ff <= mct_pkg::RST_WORD;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // match outputs; a match in the write cycle wins over software
   always_comb begin
      nxt_mat = mat_ff;
      if (WR & (ADDR == mct_pkg::OFF_EXT)) begin
         nxt_mat = WDATA[mct_pkg::N_MATCH-1:0];
      end
      for (int i = 0; i < mct_pkg::N_MATCH; i++) begin
         if (hit[i]) begin
            unique case (mct_pkg::mct_act_type'(act_ff[2*i +: 2]))
               mct_pkg::ACT_NONE   : nxt_mat[i] = nxt_mat[i];
               mct_pkg::ACT_LOW    : nxt_mat[i] = 1'b0;
               mct_pkg::ACT_HIGH   : nxt_mat[i] = 1'b1;
               mct_pkg::ACT_TOGGLE : nxt_mat[i] = ~mat_ff[i];
            endcase
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mat_ff <= '0;
      end else begin
         mat_ff <= nxt_mat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         en_ff   <= 1'b0;
         rst_ff  <= 1'b0;
         mode_ff <= mct_pkg::MODE_TIMER;
         csel_ff <= 1'b0;
      end else begin
         if (WR & (ADDR == mct_pkg::OFF_CTRL)) begin
            en_ff   <= WDATA[mct_pkg::CTRL_EN];
            rst_ff  <= WDATA[mct_pkg::CTRL_RST];
            mode_ff <= mct_pkg::mct_mode_type'(WDATA[mct_pkg::CTRL_MODE +: 2]);
            csel_ff <= WDATA[mct_pkg::CTRL_CSEL];
         end
         if (|hit_stop) begin
            en_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         presc_ff <= mct_pkg::RST_WORD;
         mctl_ff  <= '0;
         cctl_ff  <= '0;
         act_ff   <= '0;
         mask_ff  <= mct_pkg::RST_WORD;
         for (int i = 0; i < mct_pkg::N_MATCH; i++) begin
            match_ff[i] <= mct_pkg::RST_WORD;
         end
      end else if (WR) begin
         if (ADDR == mct_pkg::OFF_PRESC) begin
            presc_ff <= fit(WDATA);
         end
         if (ADDR == mct_pkg::OFF_MCTL) begin
            mctl_ff <= WDATA[11:0];
         end
         if (ADDR == mct_pkg::OFF_CCTL) begin
            cctl_ff <= WDATA[8:0];
         end
         if (ADDR == mct_pkg::OFF_EXT) begin
            act_ff <= WDATA[mct_pkg::EXT_ACT +: 8];
         end
         if (ADDR == mct_pkg::OFF_MASK) begin
            mask_ff <= {26'h0, WDATA[5:0]};
         end
         for (int i = 0; i < mct_pkg::N_MATCH; i++) begin
            if (at(ADDR, mct_pkg::OFF_MATCH0, i)) begin
               match_ff[i] <= fit(WDATA);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // sticky status, write one to clear, new event wins
   always_comb begin
      nxt_stat = stat_ff;
      if (WR & (ADDR == mct_pkg::OFF_STAT)) begin
         nxt_stat = stat_ff & ~WDATA;
      end
      nxt_stat[mct_pkg::N_MATCH-1:0] = nxt_stat[mct_pkg::N_MATCH-1:0] | hit_int;
      for (int i = 0; i < mct_pkg::N_CAP; i++) begin
         if (cap_ev[i] & cctl_ff[i*mct_pkg::CCTL_W + mct_pkg::CCTL_INT]) begin
            nxt_stat[mct_pkg::STAT_CAP + i] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stat_ff <= mct_pkg::RST_WORD;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq_ff  <= |(nxt_stat & mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // read port
   always_comb begin
      rd_word = mct_pkg::RST_WORD;
      unique case (ADDR)
         mct_pkg::OFF_STAT   : rd_word = stat_ff;
         mct_pkg::OFF_MASK   : rd_word = mask_ff;
         mct_pkg::OFF_CTRL   : rd_word = {27'h0, csel_ff, mode_ff, rst_ff, en_ff};
         mct_pkg::OFF_COUNT  : rd_word = cnt_ff;
         mct_pkg::OFF_PRESC  : rd_word = presc_ff;
         mct_pkg::OFF_PCOUNT : rd_word = pc;
         mct_pkg::OFF_MCTL   : rd_word = {20'h0, mctl_ff};
         mct_pkg::OFF_CCTL   : rd_word = {23'h0, cctl_ff};
         mct_pkg::OFF_EXT    : rd_word = {20'h0, act_ff, mat_ff};
         default             : rd_word = mct_pkg::RST_WORD;
      endcase
      for (int i = 0; i < mct_pkg::N_MATCH; i++) begin
         if (at(ADDR, mct_pkg::OFF_MATCH0, i)) begin
            rd_word = match_ff[i];
         end
      end
      for (int i = 0; i < mct_pkg::N_CAP; i++) begin
         if (at(ADDR, mct_pkg::OFF_CAPT0, i)) begin
            rd_word = cap_val[i];
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_ff <= mct_pkg::RST_WORD;
      end else begin
         rdata_ff <= RD ? rd_word : mct_pkg::RST_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   a_width_half : assert property (!WIDE32 |-> (cnt_ff[31:16] == 16'h0) && (pc[31:16] == 16'h0))
      else $error("16-bit variant exceeded its width");
   a_timer_advance : assert property ((tick & run & ~wr_count & ~rst_ff & ~cap_clear & ~|hit_rst)
      |=> cnt_ff == fit($past(cnt_ff) + 32'h1))
      else $error("timer did not advance on tick");
   a_counter_hold : assert property ((mode_ff != mct_pkg::MODE_TIMER) & ~count_edge & ~wr_count
      & ~rst_ff & ~cap_clear |=> $stable(cnt_ff))
      else $error("counter moved without an input edge");
   a_match_irq : assert property (hit_int[0] |=> stat_ff[0] ##1 (stat_ff[0] || $past(WR)))
      else $error("match interrupt flag not set");
   a_match_cont : assert property ((hit[1] & ~hit_rst[1] & ~|hit_rst & ~|hit_stop & ~wr_count
      & ~(WR & (ADDR == mct_pkg::OFF_CTRL)))
      |=> (cnt_ff == fit($past(cnt_ff) + 32'h1)) && en_ff)
      else $error("continuing match disturbed the counter");
   a_match_stop : assert property (|hit_stop |=> !en_ff ##1 ($stable(cnt_ff) || $past(WR) || $past(cap_clear)))
      else $error("stop on match did not halt the counter");
   a_match_reset : assert property ((|hit_rst & ~wr_count) |=> (cnt_ff == 32'h0))
      else $error("reset on match did not clear the counter");
   a_ext_toggle : assert property ((hit[2] & (act_ff[5:4] == mct_pkg::ACT_TOGGLE) & ~(WR & (ADDR == mct_pkg::OFF_EXT)))
      |=> (mat_ff[2] != $past(mat_ff[2])))
      else $error("match output did not toggle");
   a_cap_irq : assert property ((cap_ev[0] & cctl_ff[mct_pkg::CCTL_INT]) |=> stat_ff[mct_pkg::STAT_CAP])
      else $error("capture interrupt flag not set");
   a_cap_clear : assert property ((cap_clear & ~wr_count) |=> (cnt_ff == 32'h0) && (pc == 32'h0))
      else $error("capture clear missed counter or prescaler");
   a_hit_equal : assert property ((hit_int[0] & hit_rst[0] & ~wr_count) |=> (cnt_ff == 32'h0) && stat_ff[0])
      else $error("match actions did not apply together");
   a_irq_level : assert property (IRQ == |(stat_ff & $past(mask_ff)))
      else $error("interrupt low with unmasked flag");

   c_match_reset : cover property (|hit_rst ##1 (cnt_ff == 32'h0));
   c_capture_ev  : cover property (cap_ev[1] ##1 stat_ff[mct_pkg::STAT_CAP + 1]);
   c_width_clear : cover property (cap_clear ##[1:20] cap_ev[0]);
   c_irq_raise   : cover property (!IRQ ##1 IRQ);
endmodule

// file: bench/mct_pin_model.sv
// Purpose: far-side pins driving the capture inputs
// Assumes: bench sets the wanted pin levels
// Notes:   pins change only on the rising edge
`timescale 1ns/1ps
module mct_pin_model (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [1:0] req,
   output logic      [1:0] cap
);
   // registered so the block sees clean synchronous levels
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cap <= 2'h0;
      end else begin
         cap <= req;
      end
   end
endmodule

// file: bench/tb_match_capture_counter_timer.sv
// Purpose: register-level tests of the counter-timer
// Assumes: default 32-bit variant
// Notes:   expected values derived from the register map
`timescale 1ns/1ps
module tb_match_capture_counter_timer;
   logic        CLK    = 1'b0;
   logic        ARST_N = 1'b0;
   logic [7:0]  ADDR   = 8'h0;
   logic [31:0] WDATA  = 32'h0;
   logic        WR     = 1'b0;
   logic        RD     = 1'b0;
   logic [31:0] RDATA;
   logic [1:0]  pin_req = 2'h0;
   logic [1:0]  CAP;
   logic [3:0]  MAT;
   logic        IRQ;
   int          err_total = 0;
   int          checked   = 0;
   always #25 CLK = ~CLK;
   mct_timer mct_timer_i (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .CAP(CAP), .MAT(MAT), .IRQ(IRQ));
   mct_pin_model mct_pin_model_i (.clk(CLK), .arst_n(ARST_N), .req(pin_req), .cap(CAP));
   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK);
      RD   <= 1'b0;
      #1;
      chk(what, exp, RDATA);
   endtask
   task automatic pulse;
      @(posedge CLK);
      pin_req <= 2'h1;
      repeat (3) @(posedge CLK);
      pin_req <= 2'h0;
      repeat (3) @(posedge CLK);
   endtask
   task automatic wait_irq(input int n);
      repeat (n) begin
         if (IRQ === 1'b1) break;
         cyc(1);
      end
   endtask
   task automatic give_verdict;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(2000 * 50);
      err_total++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge CLK);
      ARST_N <= 1'b1;
      rd(mct_pkg::OFF_CTRL, 32'h0, "ctrl");
      rd(mct_pkg::OFF_STAT, 32'h0, "stat");
      rd(8'h2c, 32'h0, "unmapped");
      // reset-on-match with toggle output and interrupt
      wr(mct_pkg::OFF_PRESC, 32'h2);
      wr(mct_pkg::OFF_MATCH0, 32'h3);
      wr(mct_pkg::OFF_MCTL, 32'h3);
      wr(mct_pkg::OFF_MASK, 32'h1);
      wr(mct_pkg::OFF_EXT, 32'h30);
      wr(mct_pkg::OFF_CTRL, 32'h1);
      wait_irq(60);
      chk("irq", 32'h1, {31'h0, IRQ});
      chk("mat", 32'h1, {28'h0, MAT});
      wr(mct_pkg::OFF_CTRL, 32'h0);
      rd(mct_pkg::OFF_STAT, 32'h1, "stat");
      wr(mct_pkg::OFF_MASK, 32'h0);
      cyc(2);
      chk("irq", 32'h0, {31'h0, IRQ});
      wr(mct_pkg::OFF_STAT, 32'h3f);
      rd(mct_pkg::OFF_STAT, 32'h0, "stat");
      // stop on match, set-high and set-low outputs
      wr(mct_pkg::OFF_COUNT, 32'h0);
      wr(mct_pkg::OFF_PRESC, 32'h1);
      wr(mct_pkg::OFF_MCTL, 32'h29);
      wr(8'(mct_pkg::OFF_MATCH0 + mct_pkg::OFF_STRIDE), 32'h5);
      wr(mct_pkg::OFF_EXT, 32'h62);
      wr(mct_pkg::OFF_CTRL, 32'h1);
      cyc(40);
      rd(mct_pkg::OFF_CTRL, 32'h0, "ctrl");
      rd(mct_pkg::OFF_COUNT, 32'h6, "count");
      rd(mct_pkg::OFF_STAT, 32'h3, "stat");
      chk("mat", 32'h1, {28'h0, MAT});
      // capture with interrupt
      wr(mct_pkg::OFF_STAT, 32'h3f);
      wr(mct_pkg::OFF_CCTL, 32'h5);
      pulse();
      rd(mct_pkg::OFF_CAPT0, 32'h6, "capture");
      rd(mct_pkg::OFF_STAT, 32'h10, "stat");
      wr(mct_pkg::OFF_MASK, 32'h10);
      cyc(2);
      chk("irq", 32'h1, {31'h0, IRQ});
      // counter mode on rising edges of input 0
      wr(mct_pkg::OFF_COUNT, 32'h0);
      wr(mct_pkg::OFF_CTRL, 32'h5);
      repeat (3) pulse();
      rd(mct_pkg::OFF_COUNT, 32'h3, "count");
      // capture edge clears counter
      wr(mct_pkg::OFF_PRESC, 32'hff);
      wr(mct_pkg::OFF_COUNT, 32'h9);
      wr(mct_pkg::OFF_CCTL, 32'h40);
      wr(mct_pkg::OFF_CTRL, 32'h1);
      pulse();
      rd(mct_pkg::OFF_COUNT, 32'h0, "count");
      // falling and both-edge counting, capture on falling edge, toggle on match 2
      wr(mct_pkg::OFF_CCTL, 32'h2);
      wr(mct_pkg::OFF_COUNT, 32'h0);
      wr(8'(mct_pkg::OFF_MATCH0 + 2 * mct_pkg::OFF_STRIDE), 32'h1);
      wr(mct_pkg::OFF_EXT, 32'h300);
      wr(mct_pkg::OFF_CTRL, 32'h9);
      repeat (2) pulse();
      rd(mct_pkg::OFF_COUNT, 32'h2, "count");
      rd(mct_pkg::OFF_CAPT0, 32'h1, "capture");
      chk("mat", 32'h4, {28'h0, MAT});
      wr(mct_pkg::OFF_CTRL, 32'hd);
      pulse();
      rd(mct_pkg::OFF_COUNT, 32'h4, "count");
      rd(mct_pkg::OFF_CAPT0, 32'h3, "capture");
      give_verdict();
   end
endmodule
